// file: logic/vic_pkg.sv
// Package: register map, vectors and constants of the vectored interrupt controller
package vic_pkg;

    // ======================================================
    // Register byte offsets
    localparam logic [7:0] CTRL_OFF      = 8'h00;
    localparam logic [7:0] EDGE_OFF      = 8'h04;
    localparam logic [7:0] ENABLE_OFF    = 8'h08;
    localparam logic [7:0] FLAG_OFF      = 8'h0c;
    localparam logic [7:0] MEMBER_OFF    = 8'h10;
    localparam logic [7:0] PINCFG_OFF    = 8'h14;
    localparam logic [7:0] STATUS_OFF    = 8'h18;

    // ======================================================
    // Source slots, in priority order (slot 0 highest)
    localparam int NSRC    = 14;
    localparam int NGRP    = 6;
    localparam int NPIN    = 4;
    localparam int NMEMBER = 24;

    localparam logic [7:0] VECTORS [NSRC] = '{
        8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
        8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c};

    // Slot kinds: pin index per slot (or none), group index per slot (or none)
    localparam logic [NSRC-1:0] PIN_SLOT = 14'b00_1100_0000_0011;
    localparam logic [NSRC-1:0] GRP_SLOT = 14'b11_0010_0101_1000;
    localparam int PIN_OF [NSRC] = '{0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 2, 3, 0, 0};
    localparam int GRP_OF [NSRC] = '{0, 0, 0, 0, 1, 0, 2, 0, 0, 3, 0, 0, 4, 5};
    localparam int SLOT_CMP = 2;
    localparam int SLOT_ADC = 5;
    localparam int SLOT_TB0 = 7;
    localparam int SLOT_TB1 = 8;

    // Group of each member source: four members per group
    localparam int MEMBERS_PER_GRP = 4;

    // ======================================================
    // Edge select codes
    localparam logic [1:0] EDGE_OFF_CODE = 2'h0;
    localparam logic [1:0] EDGE_RISE     = 2'h1;
    localparam logic [1:0] EDGE_FALL     = 2'h2;
    localparam logic [1:0] EDGE_BOTH     = 2'h3;

    // ======================================================
    // Reset values
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        VIC_IDLE = 2'b00,
        VIC_REQ  = 2'b01
    } vic_state_t;

    typedef enum logic [1:0] {
        VIC_RSP_OKAY   = 2'b00,
        VIC_RSP_SLVERR = 2'b10
    } vic_resp_t;

endpackage

// file: logic/vic_controller.sv
// Vectored interrupt controller with edge-triggered pins and AXI4-Lite registers
`timescale 1ns/10ps
// What this block does
// - Events other than pin edges set request flags regardless of enables
// - Flag vectors only when its enable set
// - Global enable low suppresses all interrupts
// - Core pushes next PC, loads vector
// - Return instruction pops the saved PC
// - Taking an interrupt clears global enable
// - Flags still latch while globally disabled
// - Full stack blocks raising every new request
// - Lowest vector address wins simultaneous requests
// - Individual vectors fixed per source table
// - Six groups share one vector each
// - Service clears individual and group flags
// - Any event setting a clear flag wakes from sleep
// - Pin edge sets its pin flag
// - Pin vectors need global, enable, edge
// - Pin active needs enable, routing, input
// - Pin service clears pin flag, global
// - Rising, falling or both edge trigger
// - Edge code can disable pin entirely
// - Pull-up remains with pin as interrupt
// - Any member event sets its group flag
module vic_controller (
    input  wire logic                   aclk,            // System clock, 20 MHz
    input  wire logic                   aresetn,         // Synchronous reset, active low
    input  wire logic [7:0]             s_axi_awaddr,    // Write address
    input  wire logic                   s_axi_awvalid,   // Write address valid
    output logic                        s_axi_awready,   // Write address ready
    input  wire logic [31:0]            s_axi_wdata,     // Write data
    input  wire logic [3:0]             s_axi_wstrb,     // Write strobes
    input  wire logic                   s_axi_wvalid,    // Write data valid
    output logic                        s_axi_wready,    // Write data ready
    output logic [1:0]                  s_axi_bresp,     // Write response
    output logic                        s_axi_bvalid,    // Write response valid
    input  wire logic                   s_axi_bready,    // Write response ready
    input  wire logic [7:0]             s_axi_araddr,    // Read address
    input  wire logic                   s_axi_arvalid,   // Read address valid
    output logic                        s_axi_arready,   // Read address ready
    output logic [31:0]                 s_axi_rdata,     // Read data
    output logic [1:0]                  s_axi_rresp,     // Read response
    output logic                        s_axi_rvalid,    // Read data valid
    input  wire logic                   s_axi_rready,    // Read data ready
    input  wire logic [3:0]             ext_irq_pins,    // External interrupt pin levels
    input  wire logic                   comparator_event,// Comparator output changed, pulse
    input  wire logic                   converter_event, // Conversion finished, pulse
    input  wire logic                   timebase0_event, // Time base 0 tick, pulse
    input  wire logic                   timebase1_event, // Time base 1 tick, pulse
    input  wire logic [23:0]            member_events,   // Group member source events, pulses
    input  wire logic                   stack_full,      // Core return stack is full
    input  wire logic                   core_ack,        // Core accepts the vector, pulse
    input  wire logic                   core_return_from_isr_instr,       // Core executed return from service
    output logic                        irq_req,         // Interrupt request to core, level
    output logic [7:0]                  irq_vector,      // Vector address for the core
    output logic                        wake_up,         // Wake from sleep or idle, pulse
    output logic [3:0]                  pin_pullup_en    // Pull-up enables to pin pads
);

    // ======================================================
    // State
    typedef struct packed {
        logic                           gie;
        logic [7:0]                     edge_sel;
        logic [13:0]                    enables;
        logic [13:0]                    flags;
        logic [23:0]                    member_flags;
        logic [3:0]                     pin_route;
        logic [3:0]                     pin_input;
        logic [3:0]                     pin_pull;
        logic [3:0]                     pin_sync1;
        logic [3:0]                     pin_sync2;
        logic [3:0]                     pin_prev;
        logic                           req;
        logic [7:0]                     vec;
        logic [3:0]                     slot;
        logic                           wake;
        logic                           aw_got;
        logic                           w_got;
        logic [7:0]                     awaddr;
        logic [31:0]                    wdata;
        logic                           bvalid;
        logic                           rvalid;
        logic [31:0]                    rdata;
        logic [1:0]                     bresp;
        logic [1:0]                     rresp;
    } vic_state_s_t;

    vic_state_s_t st_reg;
    vic_state_s_t st_next;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == vic_pkg::CTRL_OFF) || (a == vic_pkg::EDGE_OFF) ||
                     (a == vic_pkg::ENABLE_OFF) || (a == vic_pkg::FLAG_OFF) ||
                     (a == vic_pkg::MEMBER_OFF) || (a == vic_pkg::PINCFG_OFF) ||
                     (a == vic_pkg::STATUS_OFF);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
                r[b*8 +: 8] = d[b*8 +: 8];
        end
        merge = r;
    endfunction

    // ======================================================
    // Event sources
    logic [3:0]  pin_edge;
    logic [3:0]  pin_active;
    logic [3:0]  pin_en;
    logic [13:0] raw_set;
    logic [5:0]  grp_set;

    genvar gp;
    generate
        for (gp = 0; gp < vic_pkg::NPIN; gp++)
        begin : g_pin
            logic [1:0] sel;
            logic       rise;
            logic       fall;
            assign sel  = st_reg.edge_sel[gp*2 +: 2];
            assign rise = st_reg.pin_sync2[gp] & ~st_reg.pin_prev[gp];
            assign fall = ~st_reg.pin_sync2[gp] & st_reg.pin_prev[gp];
            // Routing, direction and enable all gate the pin function
            assign pin_active[gp] = st_reg.pin_route[gp] & st_reg.pin_input[gp] & pin_en[gp];
            assign pin_edge[gp] = pin_active[gp] &&
                                  (((sel == vic_pkg::EDGE_RISE) && rise) ||
                                   ((sel == vic_pkg::EDGE_FALL) && fall) ||
                                   ((sel == vic_pkg::EDGE_BOTH) && (rise || fall)));
        end
        for (gp = 0; gp < vic_pkg::NGRP; gp++)
        begin : g_grp
            // Any newly raised member sets the group flag
            assign grp_set[gp] = |member_events[gp*vic_pkg::MEMBERS_PER_GRP +: vic_pkg::MEMBERS_PER_GRP];
        end
    endgenerate

    always_comb
    begin
        raw_set = '0;
        for (int i = 0; i < vic_pkg::NSRC; i++)
        begin
            if (vic_pkg::PIN_SLOT[i])
                raw_set[i] = pin_edge[vic_pkg::PIN_OF[i]];
            else if (vic_pkg::GRP_SLOT[i])
                raw_set[i] = grp_set[vic_pkg::GRP_OF[i]];
        end
        raw_set[vic_pkg::SLOT_CMP] = comparator_event;
        raw_set[vic_pkg::SLOT_ADC] = converter_event;
        raw_set[vic_pkg::SLOT_TB0] = timebase0_event;
        raw_set[vic_pkg::SLOT_TB1] = timebase1_event;
    end

    // ======================================================
    // Arbitration
    logic [13:0] pending;
    logic        any_pend;
    logic [3:0]  win;

    // Pins also need a non-disabled edge code to vector
    always_comb
    begin
        pending = st_reg.flags & st_reg.enables;
        pin_en = '0;
        for (int i = 0; i < vic_pkg::NSRC; i++)
        begin
            if (vic_pkg::PIN_SLOT[i])
                pin_en[vic_pkg::PIN_OF[i]] = st_reg.enables[i];
            if (vic_pkg::PIN_SLOT[i] && st_reg.edge_sel[vic_pkg::PIN_OF[i]*2 +: 2] == vic_pkg::EDGE_OFF_CODE)
                pending[i] = 1'b0;
        end
        any_pend = |pending;
        win = 4'h0;
        for (int i = vic_pkg::NSRC - 1; i >= 0; i--)
        begin
            if (pending[i])
                win = 4'(i);
        end
    end

    // ======================================================
    // Next state
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_go;

    assign aw_take = s_axi_awvalid && !st_reg.aw_got && !st_reg.bvalid;
    assign w_take  = s_axi_wvalid && !st_reg.w_got && !st_reg.bvalid;
    assign ar_take = s_axi_arvalid && !st_reg.rvalid;

    always_comb
    begin
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [13:0] clr;
        logic [31:0] tmp;
        wa  = aw_take ? s_axi_awaddr : st_reg.awaddr;
        wd  = w_take ? s_axi_wdata : st_reg.wdata;
        clr = '0;
        tmp = '0;
        st_next = st_reg;
        wr_go = (st_reg.aw_got || aw_take) && (st_reg.w_got || w_take);

        st_next.pin_sync1 = ext_irq_pins;
        st_next.pin_sync2 = st_reg.pin_sync1;
        st_next.pin_prev  = st_reg.pin_sync2;
        st_next.wake = 1'b0;

        if (aw_take)
            st_next.awaddr = s_axi_awaddr;
        if (w_take)
            st_next.wdata = s_axi_wdata;
        st_next.aw_got = (st_reg.aw_got || aw_take) && !wr_go;
        st_next.w_got  = (st_reg.w_got || w_take) && !wr_go;

        // Register writes; hardware sets below are applied after, so a set wins
        if (wr_go)
        begin
            st_next.bvalid = 1'b1;
            st_next.bresp  = addr_known(wa) ? vic_pkg::VIC_RSP_OKAY : vic_pkg::VIC_RSP_SLVERR;
            case (wa)
                vic_pkg::CTRL_OFF:
                    if (s_axi_wstrb[0])
                        st_next.gie = wd[0];
                vic_pkg::EDGE_OFF:
                    if (s_axi_wstrb[0])
                        st_next.edge_sel = wd[7:0];
                vic_pkg::ENABLE_OFF:
                begin
                    tmp = merge({18'h0, st_reg.enables}, wd, s_axi_wstrb);
                    st_next.enables = tmp[13:0];
                end
                vic_pkg::FLAG_OFF:
                begin
                    tmp = merge({18'h0, st_reg.flags}, wd, s_axi_wstrb);
                    st_next.flags = tmp[13:0];
                end
                vic_pkg::MEMBER_OFF:
                begin
                    tmp = merge({8'h0, st_reg.member_flags}, wd, s_axi_wstrb);
                    st_next.member_flags = tmp[23:0];
                end
                vic_pkg::PINCFG_OFF:
                    if (s_axi_wstrb[1:0] == 2'h3)
                    begin
                        st_next.pin_route = wd[3:0];
                        st_next.pin_input = wd[7:4];
                        st_next.pin_pull  = wd[11:8];
                    end
                default:
                    st_next.gie = st_next.gie;
            endcase
        end
        else if (st_reg.bvalid && s_axi_bready)
            st_next.bvalid = 1'b0;

        if (ar_take)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = addr_known(s_axi_araddr) ? vic_pkg::VIC_RSP_OKAY : vic_pkg::VIC_RSP_SLVERR;
            case (s_axi_araddr)
                vic_pkg::CTRL_OFF:   st_next.rdata = {31'h0, st_reg.gie};
                vic_pkg::EDGE_OFF:   st_next.rdata = {24'h0, st_reg.edge_sel};
                vic_pkg::ENABLE_OFF: st_next.rdata = {18'h0, st_reg.enables};
                vic_pkg::FLAG_OFF:   st_next.rdata = {18'h0, st_reg.flags};
                vic_pkg::MEMBER_OFF: st_next.rdata = {8'h0, st_reg.member_flags};
                vic_pkg::PINCFG_OFF: st_next.rdata = {20'h0, st_reg.pin_pull, st_reg.pin_input, st_reg.pin_route};
                vic_pkg::STATUS_OFF: st_next.rdata = {19'h0, st_reg.slot, st_reg.vec, st_reg.req};
                default:             st_next.rdata = vic_pkg::ZERO_RST;
            endcase
        end
        else if (st_reg.rvalid && s_axi_rready)
            st_next.rvalid = 1'b0;

        // Request to core; vector held stable while raised
        if (st_reg.req)
        begin
            if (core_ack)
            begin
                st_next.req = 1'b0;
                st_next.gie = 1'b0;
                clr[st_reg.slot] = 1'b1;
            end
        end
        else if (st_reg.gie && !stack_full && any_pend)
        begin
            st_next.req  = 1'b1;
            st_next.slot = win;
            st_next.vec  = vic_pkg::VECTORS[win];
        end
        if (core_ack && st_reg.req)
            st_next.flags = st_next.flags & ~clr;

        // Hardware events are applied last so a set beats any clear
        st_next.flags = st_next.flags | raw_set;
        st_next.member_flags = st_next.member_flags | member_events;
        st_next.wake = |(raw_set & ~st_reg.flags);

        if (!aresetn)
        begin
            st_next = '0;
            st_next.pin_sync1 = ext_irq_pins;
            st_next.pin_sync2 = ext_irq_pins;
            st_next.pin_prev  = ext_irq_pins;
        end
    end

    always_ff @(posedge aclk)
        st_reg <= st_next;

    // ======================================================
    // Outputs
    assign s_axi_awready = aw_take;
    assign s_axi_wready  = w_take;
    assign s_axi_arready = ar_take;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;
    assign irq_req       = st_reg.req;
    assign irq_vector    = st_reg.vec;
    assign wake_up       = st_reg.wake;
    assign pin_pullup_en = st_reg.pin_pull;

    // ======================================================
    // Checks
    a_gie_suppress: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(irq_req) |-> $past(st_reg.gie))
        else $error("request raised with global enable low");
    a_stack_block: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(irq_req) |-> !$past(stack_full))
        else $error("request raised while stack full");
    a_ack_clears_gie: assert property (@(posedge aclk) disable iff (!aresetn)
        (irq_req && core_ack && !wr_go) |=> !st_reg.gie && !irq_req)
        else $error("global enable not cleared on service");
    a_enable_needed: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(irq_req) |-> ($past(st_reg.enables) & (14'h1 << st_reg.slot)) != 14'h0)
        else $error("disabled source vectored");
    a_vec_stable: assert property (@(posedge aclk) disable iff (!aresetn)
        (irq_req && !core_ack) |=> $stable(irq_vector))
        else $error("vector changed while pending");
    a_vector_map: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_req |-> irq_vector == {2'h0, st_reg.slot + 4'h1 + {3'h0, st_reg.slot >= 4'h2}, 2'h0})
        else $error("vector does not match slot");
    a_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        comparator_event |=> st_reg.flags[2])
        else $error("comparator flag not set");
    a_member_group: assert property (@(posedge aclk) disable iff (!aresetn)
        member_events[4] |=> st_reg.flags[4] && st_reg.member_flags[4])
        else $error("group flag not set by member");
    a_wake_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        (timebase0_event && !st_reg.flags[7]) |=> wake_up)
        else $error("no wake on new flag");

endmodule

// file: testbench/vic_core_model.sv
// Behavioural model of the processor core that takes vectors from the controller
`timescale 1ns/10ps
module vic_core_model #(
    parameter int DEPTH = 8
) (
    input  wire logic       aclk,       // System clock
    input  wire logic       aresetn,    // Synchronous reset, active low
    input  wire logic       irq_req,    // Request from the controller
    input  wire logic [7:0] irq_vector, // Vector offered
    input  wire logic [3:0] ack_delay,  // Cycles to wait before taking a vector
    input  wire logic       force_full, // Test forces a full stack
    output logic            core_ack,   // Vector taken, pulse
    output logic            core_return_from_isr_instr,  // Return from service, pulse
    output logic            stack_full, // Return stack full
    output logic [7:0]      last_vec,   // Last vector loaded into the program counter
    output logic [7:0]      n_taken     // Vectors taken so far
);
    logic [3:0] wait_cnt;
    logic [3:0] depth;
    logic [2:0] svc_cnt;

    assign stack_full = force_full || (depth == 4'(DEPTH));

    // ==================================================
    // Push on take, pop a few cycles later on return
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {core_ack, core_return_from_isr_instr, wait_cnt, depth, svc_cnt, last_vec, n_taken} <= '0;
        end
        else
        begin
            core_ack <= 1'b0;
            core_return_from_isr_instr <= 1'b0;
            if (svc_cnt != 3'h0)
                svc_cnt <= svc_cnt - 3'h1;
            if (svc_cnt == 3'h1)
            begin
                core_return_from_isr_instr <= 1'b1;
                depth <= depth - 4'h1;
            end
            if (irq_req && !core_ack && !stack_full)
            begin
                wait_cnt <= wait_cnt + 4'h1;
                if (wait_cnt == ack_delay)
                begin
                    core_ack <= 1'b1;
                    last_vec <= irq_vector;
                    n_taken <= n_taken + 8'h1;
                    depth <= depth + 4'h1;
                    svc_cnt <= 3'h4;
                    wait_cnt <= 4'h0;
                end
            end
            else
                wait_cnt <= 4'h0;
        end
    end
endmodule

// file: testbench/tb_vic_controller.sv
// Testbench: register access, vectoring, priority and pin edge scenarios
`timescale 1ns/10ps
module tb_vic_controller;
    logic        aclk = 0;
    logic        aresetn = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [3:0]  ext_irq_pins = 0, ev = 0, ack_delay = 0, pin_pullup_en;
    logic [23:0] member_events = 0;
    logic        force_full = 0, stack_full, core_ack, core_return_from_isr_instr, irq_req, wake_up;
    logic [7:0]  irq_vector, last_vec, n_taken;
    wire         comparator_event = ev[0];
    wire         converter_event = ev[1];
    wire         timebase0_event = ev[2];
    wire         timebase1_event = ev[3];
    int          num_errors = 0;
    int          comparisons = 0;
    int          wakes = 0;
    int          w0;
    int          ps[4] = '{0, 1, 10, 11};

    vic_controller u_dut (.*);
    vic_core_model u_core (.*);

    always #25 aclk = ~aclk;
    always @(posedge aclk)
        if (wake_up === 1'b1)
            wakes <= wakes + 1;

    // ==================================================
    // Comparison, verdict and bus tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (num_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic ta;
        logic tw;
        {ta, tw} = 2'b00;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do
        begin
            @(posedge aclk);
            ta |= s_axi_awready;
            tw |= s_axi_wready;
            s_axi_awvalid <= !ta;
            s_axi_wvalid <= !tw;
        end
        while (!(ta && tw));
        do
            @(posedge aclk);
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do
            @(posedge aclk);
        while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do
            @(posedge aclk);
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, exp);
        check(s_axi_rresp, er);
    endtask

    task automatic pulse(input logic [3:0] e, input logic [23:0] m);
        @(posedge aclk);
        {ev, member_events} <= {e, m};
        @(posedge aclk);
        {ev, member_events} <= '0;
        repeat (5) @(posedge aclk);
    endtask

    // Waits for the core to take one vector, then compares it
    task automatic take(input logic [7:0] v);
        logic [7:0] n0;
        n0 = n_taken;
        for (int k = 0; k < 100 && n_taken == n0; k++)
            @(posedge aclk);
        check({n_taken - n0, last_vec}, {8'h1, v});
    endtask

    // ==================================================
    // Scenarios
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int a = 0; a < 28; a += 4)
            rd(8'(a), 0);
        rd(8'h1c, 0, 2'h2);
        wr(8'h1c, 1, 2'h2);
        wr(vic_pkg::CTRL_OFF, 1);
        pulse(4'hf, 0);
        rd(vic_pkg::FLAG_OFF, 32'h1a4);
        check(irq_req, 0);
        check(wakes != 0, 1);
        w0 = wakes;
        pulse(4'hf, 0);
        check(wakes, w0);
        wr(vic_pkg::CTRL_OFF, 0);
        wr(vic_pkg::FLAG_OFF, 0);
        wr(vic_pkg::ENABLE_OFF, 32'ha0);
        pulse(4'h2, 0);
        check(irq_req, 0);
        wr(vic_pkg::CTRL_OFF, 1);
        take(8'h1c);
        rd(vic_pkg::CTRL_OFF, 0);
        rd(vic_pkg::FLAG_OFF, 0);
        pulse(4'h4, 0);
        rd(vic_pkg::FLAG_OFF, 32'h80);
        check(irq_req, 0);
        wr(vic_pkg::CTRL_OFF, 1);
        take(8'h24);
        ack_delay <= 4'h3;
        force_full <= 1'b1;
        pulse(4'h2, 0);
        wr(vic_pkg::CTRL_OFF, 1);
        repeat (8) @(posedge aclk);
        check(irq_req, 0);
        force_full <= 1'b0;
        take(8'h1c);
        ack_delay <= 4'h0;
        wr(vic_pkg::ENABLE_OFF, 32'h3fff);
        wr(vic_pkg::EDGE_OFF, 32'hff);
        wr(vic_pkg::FLAG_OFF, 32'h3fff);
        for (int i = 0; i < vic_pkg::NSRC; i++)
        begin
            wr(vic_pkg::CTRL_OFF, 1);
            take(vic_pkg::VECTORS[i]);
        end
        rd(vic_pkg::FLAG_OFF, 0);
        pulse(0, 24'h10);
        rd(vic_pkg::MEMBER_OFF, 32'h10);
        rd(vic_pkg::FLAG_OFF, 32'h10);
        wr(vic_pkg::CTRL_OFF, 1);
        take(8'h18);
        rd(vic_pkg::MEMBER_OFF, 32'h10);
        wr(vic_pkg::MEMBER_OFF, 0);
        rd(vic_pkg::MEMBER_OFF, 0);
        wr(vic_pkg::ENABLE_OFF, 32'hc03);
        wr(vic_pkg::PINCFG_OFF, 32'haff);
        rd(vic_pkg::PINCFG_OFF, 32'haff);
        check(pin_pullup_en, 4'ha);
        for (int p = 0; p < 4; p++)
            for (logic [2:0] c = 0; c < 4; c++)
            begin
                wr(vic_pkg::EDGE_OFF, 32'(c[1:0]) << (2 * p));
                wr(vic_pkg::FLAG_OFF, 0);
                @(posedge aclk) ext_irq_pins[p] <= 1'b1;
                repeat (6) @(posedge aclk);
                rd(vic_pkg::FLAG_OFF, {31'h0, c[0]} << ps[p]);
                wr(vic_pkg::FLAG_OFF, 0);
                @(posedge aclk) ext_irq_pins[p] <= 1'b0;
                repeat (6) @(posedge aclk);
                rd(vic_pkg::FLAG_OFF, {31'h0, c[1]} << ps[p]);
            end
        wr(vic_pkg::EDGE_OFF, {28'h0, vic_pkg::EDGE_RISE, 4'h0});
        wr(vic_pkg::FLAG_OFF, 0);
        wr(vic_pkg::ENABLE_OFF, 32'h400);
        wr(vic_pkg::CTRL_OFF, 1);
        @(posedge aclk) ext_irq_pins[2] <= 1'b1;
        take(8'h30);
        rd(vic_pkg::FLAG_OFF, 0);
        rd(vic_pkg::CTRL_OFF, 0);
        conclude();
    end

    // Watchdog far beyond the several hundred cycles the scenarios need
    initial
    begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        conclude();
    end
endmodule
